/* pin_edge_detect.sv */
// two-flop synchroniser and edge selector for one pin
// assumes the pin is asynchronous to clk_sys_i
module pin_edge_detect (
   input  wire logic       clk_sys_i,
   input  wire logic       rst_n_i,
   input  wire logic       pin_i,
   input  wire logic [1:0] edge_sel_i,
   output logic            level_o,
   output logic            rise_o,
   output logic            fall_o,
   output logic            event_o
);

   logic [1:0] sync_q;
   logic       prev_q;

   // ==========================================
   // synchroniser and previous level
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         sync_q <= 2'h0;
         prev_q <= 1'b0;
      end else begin
         sync_q <= {sync_q[0], pin_i};
         prev_q <= sync_q[1];
      end
   end

   // ==========================================
   // edge select: 00 rising, 01 falling, 1x both
   assign level_o = sync_q[1];
   assign rise_o  = sync_q[1] & ~prev_q;
   assign fall_o  = ~sync_q[1] & prev_q;
   assign event_o = edge_sel_i[1] ? (rise_o | fall_o) : (edge_sel_i[0] ? fall_o : rise_o);

endmodule

/* timer_channel_control.sv */
// timer channel 0 general registers and counter, channel 1 counter with count source,
// edge, clear, mode and general register A compare/capture control
// assumes a single 125 MHz clock, synchronous active-low reset, and asynchronous pins
`include "timer_defs.svh"

module timer_channel_control (
   input  wire logic              clk_sys_i,
   input  wire logic              rst_n_i,
   input  wire timer_pkg::reg_req_t bus_req_i,
   output logic [15:0]            rdata_o,
   input  wire logic              ext_clock_a_pin_i,
   input  wire logic              ext_clock_b_pin_i,
   input  wire logic              ch2_overflow_i,
   input  wire logic              ch1_io_a_pin_i,
   output logic                   ch1_io_a_pin_o,
   output logic                   ch1_io_a_pin_oe_n_o
);
   import timer_pkg::*;

   // ==========================================
   // decode helpers
   function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
      hit = (a == off);
   endfunction

   function automatic logic is_phase(input logic [3:0] m);
      is_phase = (m[3:2] == 2'b01);
   endfunction

   // ==========================================
   // state
   logic [15:0]  ch0_gen_q [0:3];
   logic [15:0]  ch0_count_q;
   clr_sel_t     ch0_clear_q;
   logic         ch0_eq_a_q;
   logic         ch0_eq_b_q;
   ch1_control_t ch1_ctrl_q;
   logic [3:0]   ch1_mode_q;
   io_ctrl_t     ch1_io_q;
   logic [15:0]  ch1_count_q;
   logic [15:0]  ch1_count_d;
   logic [15:0]  ch1_gen_a_q;
   logic [15:0]  ch1_gen_b_q;
   logic         ch1_eq_a_q;
   logic         ch1_eq_b_q;
   logic [1:0]   start_q;
   logic [1:0]   sync_q;
   logic         overflow_flag_q;
   logic         overflow_flag_d;
   logic         ovf_armed_q;
   logic         pin_q;
   logic [7:0]   prescale_q;
   logic [15:0]  rdata_q;

   // ==========================================
   // bus decode
   wire         wr        = bus_req_i.wr;
   wire         rd        = bus_req_i.rd;
   wire [15:0]  addr      = bus_req_i.addr;
   wire [15:0]  wdata     = bus_req_i.wdata;
   wire         ch0_gen_hit = (addr[15:3] == 13'(`CH0_GENERAL_A_ADDR >> 3));
   wire [1:0]   ch0_gen_idx = addr[2:1];
   wire         wr_ch0_gen  = wr & ch0_gen_hit;
   wire         wr_ctrl     = wr & hit(addr, `CH1_CONTROL_ADDR);
   wire         wr_mode     = wr & hit(addr, `CH1_MODE_ADDR);
   wire         wr_io       = wr & hit(addr, `CH1_IO_ADDR);
   wire         wr_status   = wr & hit(addr, `CH1_STATUS_ADDR);
   wire         rd_status   = rd & hit(addr, `CH1_STATUS_ADDR);
   wire         wr_count    = wr & hit(addr, `CH1_COUNTER_ADDR);
   wire         wr_gen_a    = wr & hit(addr, `CH1_GENERAL_A_ADDR);
   wire         wr_gen_b    = wr & hit(addr, `CH1_GENERAL_B_ADDR);
   wire         wr_start    = wr & hit(addr, `START_ADDR);
   wire         wr_sync     = wr & hit(addr, `SYNC_ADDR);
   wire         wr_ch0_cnt  = wr & hit(addr, `CH0_COUNTER_ADDR);
   wire         wr_ch0_ctrl = wr & hit(addr, `CH0_CONTROL_ADDR);

   // ==========================================
   // pin synchronisers: 0 io pin, 1 clock a, 2 clock b
   wire [2:0]   pins    = {ext_clock_b_pin_i, ext_clock_a_pin_i, ch1_io_a_pin_i};
   logic [1:0]  edge_cfg [0:2];
   logic [2:0]  pin_lvl;
   logic [2:0]  pin_rise;
   logic [2:0]  pin_fall;
   logic [2:0]  pin_ev;

   assign edge_cfg[0] = ch1_io_q.action;
   assign edge_cfg[1] = ch1_ctrl_q.edge_sel;
   assign edge_cfg[2] = ch1_ctrl_q.edge_sel;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_pin
         pin_edge_detect u_edge (
            .clk_sys_i  (clk_sys_i),
            .rst_n_i    (rst_n_i),
            .pin_i      (pins[gi]),
            .edge_sel_i (edge_cfg[gi]),
            .level_o    (pin_lvl[gi]),
            .rise_o     (pin_rise[gi]),
            .fall_o     (pin_fall[gi]),
            .event_o    (pin_ev[gi])
         );
      end
   endgenerate

   // ==========================================
   // prescaler ticks
   wire tick4   = &prescale_q[`DIV4_LOG2-1:0];
   wire tick16  = &prescale_q[`DIV16_LOG2-1:0];
   wire tick64  = &prescale_q[`DIV64_LOG2-1:0];
   wire tick256 = &prescale_q[`DIV256_LOG2-1:0];

   // ==========================================
   // channel 1 count source
   wire count_src =
      (ch1_ctrl_q.clk_sel == CLK_DIV1)   ? 1'b1 :
      (ch1_ctrl_q.clk_sel == CLK_DIV4)   ? tick4 :
      (ch1_ctrl_q.clk_sel == CLK_DIV16)  ? tick16 :
      (ch1_ctrl_q.clk_sel == CLK_DIV64)  ? tick64 :
      (ch1_ctrl_q.clk_sel == CLK_EXT_A)  ? pin_ev[1] :
      (ch1_ctrl_q.clk_sel == CLK_EXT_B)  ? pin_ev[2] :
      (ch1_ctrl_q.clk_sel == CLK_DIV256) ? tick256 :
      ch2_overflow_i;

   // quadrature from pins a and b
   wire q_up = (pin_rise[1] & ~pin_lvl[2]) | (pin_fall[1] & pin_lvl[2]) |
               (pin_rise[2] & pin_lvl[1]) | (pin_fall[2] & ~pin_lvl[1]);
   wire q_dn = (pin_rise[1] & pin_lvl[2]) | (pin_fall[1] & ~pin_lvl[2]) |
               (pin_rise[2] & ~pin_lvl[1]) | (pin_fall[2] & pin_lvl[1]);

   wire phase   = is_phase(ch1_mode_q);
   wire count_up = start_q[1] & (phase ? (q_up & ~q_dn) : count_src);
   wire count_dn = start_q[1] & phase & q_dn & ~q_up;

   // ==========================================
   // matches and captures
   wire ch0_eq_a    = (ch0_count_q == ch0_gen_q[0]);
   wire ch0_eq_b    = (ch0_count_q == ch0_gen_q[1]);
   wire ch0_match_a = ch0_eq_a & ~ch0_eq_a_q;
   wire ch0_match_b = ch0_eq_b & ~ch0_eq_b_q;
   wire ch1_eq_a    = (ch1_count_q == ch1_gen_a_q);
   wire ch1_eq_b    = (ch1_count_q == ch1_gen_b_q);
   wire ch1_match_a = ~ch1_io_q.capture & ch1_eq_a & ~ch1_eq_a_q;
   wire ch1_match_b = ch1_eq_b & ~ch1_eq_b_q;
   wire capture_a   = ch1_io_q.capture &
                      (ch1_io_q.init_or_ch0 ? ch0_match_a : pin_ev[0]);

   // ==========================================
   // counter clearing
   wire sync_both = &sync_q;
   wire ch0_own_clear = ((ch0_clear_q == CLR_GEN_A) & ch0_match_a) |
                        ((ch0_clear_q == CLR_GEN_B) & ch0_match_b);
   wire ch1_own_clear = ((ch1_ctrl_q.clear == CLR_GEN_A) & (ch1_match_a | capture_a)) |
                        ((ch1_ctrl_q.clear == CLR_GEN_B) & ch1_match_b);
   wire ch0_clear = ch0_own_clear | ((ch0_clear_q == CLR_SYNC) & sync_both & ch1_own_clear);
   wire ch1_clear = ch1_own_clear |
                    ((ch1_ctrl_q.clear == CLR_SYNC) & sync_both & ch0_own_clear);

   // ==========================================
   // next counter value and overflow
   assign ch1_count_d = ch1_clear ? `COUNTER_RESET :
                        wr_count  ? wdata :
                        count_up  ? ch1_count_q + 16'h0001 :
                        count_dn  ? ch1_count_q - 16'h0001 :
                        ch1_count_q;

   wire ovf_set   = count_up & ~ch1_clear & ~wr_count &
                    (ch1_count_q == `COUNTER_MAX);
   wire ovf_clear = wr_status & ovf_armed_q & ~wdata[`OVF_BIT];
   assign overflow_flag_d = ovf_set | (overflow_flag_q & ~ovf_clear);

   // ==========================================
   // read multiplexer
   wire [15:0] rd_mux =
      ch0_gen_hit                    ? ch0_gen_q[ch0_gen_idx] :
      hit(addr, `CH1_CONTROL_ADDR)   ? {9'h000, ch1_ctrl_q} :
      hit(addr, `CH1_MODE_ADDR)      ? (`MODE_READ_ONES | {12'h000, ch1_mode_q}) :
      hit(addr, `CH1_IO_ADDR)        ? {12'h000, ch1_io_q} :
      hit(addr, `CH1_STATUS_ADDR)    ? {11'h000, overflow_flag_q, 4'h0} :
      hit(addr, `CH1_COUNTER_ADDR)   ? ch1_count_q :
      hit(addr, `CH1_GENERAL_A_ADDR) ? ch1_gen_a_q :
      hit(addr, `CH1_GENERAL_B_ADDR) ? ch1_gen_b_q :
      hit(addr, `START_ADDR)         ? {14'h0000, start_q} :
      hit(addr, `SYNC_ADDR)          ? {14'h0000, sync_q} :
      hit(addr, `CH0_COUNTER_ADDR)   ? ch0_count_q :
      hit(addr, `CH0_CONTROL_ADDR)   ? {14'h0000, ch0_clear_q} :
      16'h0000;

   // ==========================================
   // channel 0
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 4; i++) begin
            ch0_gen_q[i] <= `GENERAL_RESET;
         end
         ch0_count_q <= `COUNTER_RESET;
         ch0_clear_q <= CLR_NONE;
         ch0_eq_a_q  <= 1'b0;
         ch0_eq_b_q  <= 1'b0;
      end else begin
         if (wr_ch0_gen) begin
            ch0_gen_q[ch0_gen_idx] <= wdata;
         end
         if (ch0_clear) begin
            ch0_count_q <= `COUNTER_RESET;
         end else if (wr_ch0_cnt) begin
            ch0_count_q <= wdata;
         end else if (start_q[0]) begin
            ch0_count_q <= ch0_count_q + 16'h0001;
         end
         if (wr_ch0_ctrl) begin
            ch0_clear_q <= clr_sel_t'(wdata[1:0]);
         end
         ch0_eq_a_q <= ch0_eq_a;
         ch0_eq_b_q <= ch0_eq_b;
      end
   end

   // ==========================================
   // channel 1 configuration
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         ch1_ctrl_q <= `CONTROL_RESET;
         ch1_mode_q <= `MODE_RESET;
         ch1_io_q   <= `IO_RESET;
         start_q    <= 2'h0;
         sync_q     <= 2'h0;
      end else begin
         if (wr_ctrl) begin
            ch1_ctrl_q <= wdata[6:0];
         end
         if (wr_mode) begin
            ch1_mode_q <= wdata[3:0];
         end
         if (wr_io) begin
            ch1_io_q <= wdata[3:0];
         end
         if (wr_start) begin
            start_q <= wdata[1:0];
         end
         if (wr_sync) begin
            sync_q <= wdata[1:0];
         end
      end
   end

   // ==========================================
   // channel 1 counter, general registers and flag
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         ch1_count_q     <= `COUNTER_RESET;
         ch1_gen_a_q     <= `GENERAL_RESET;
         ch1_gen_b_q     <= `GENERAL_RESET;
         ch1_eq_a_q      <= 1'b0;
         ch1_eq_b_q      <= 1'b0;
         overflow_flag_q <= 1'b0;
         ovf_armed_q     <= 1'b0;
      end else begin
         ch1_count_q     <= ch1_count_d;
         ch1_eq_a_q      <= ch1_eq_a;
         ch1_eq_b_q      <= ch1_eq_b;
         overflow_flag_q <= overflow_flag_d;
         if (capture_a) begin
            ch1_gen_a_q <= ch1_count_q;
         end else if (wr_gen_a) begin
            ch1_gen_a_q <= wdata;
         end
         if (wr_gen_b) begin
            ch1_gen_b_q <= wdata;
         end
         if (wr_status) begin
            ovf_armed_q <= 1'b0;
         end else if (rd_status & overflow_flag_q) begin
            ovf_armed_q <= 1'b1;
         end
      end
   end

   // ==========================================
   // compare output pin
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         pin_q <= 1'b0;
      end else if (wr_io & ~wdata[3]) begin
         pin_q <= wdata[`IO_INIT_BIT];
      end else if (ch1_match_a) begin
         case (ch1_io_q.action)
            2'h1:    pin_q <= 1'b0;
            2'h2:    pin_q <= 1'b1;
            2'h3:    pin_q <= ~pin_q;
            default: pin_q <= pin_q;
         endcase
      end
   end

   assign ch1_io_a_pin_o      = pin_q;
   assign ch1_io_a_pin_oe_n_o = ch1_io_q.capture | (ch1_io_q.action == 2'h0);

   // ==========================================
   // prescaler and read data
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         prescale_q <= 8'h00;
         rdata_q    <= 16'h0000;
      end else begin
         prescale_q <= prescale_q + 8'h01;
         rdata_q    <= rd ? rd_mux : 16'h0000;
      end
   end

   assign rdata_o = rdata_q;

endmodule

/* timer_channel_control_sva.sv */
// port checks for timer_channel_control, bound from the bench top
// assumes the offsets of timer_defs.svh and a single clock domain
`include "timer_defs.svh"
module timer_channel_control_sva (
   input wire logic                clk_sys_i,
   input wire logic                rst_n_i,
   input wire timer_pkg::reg_req_t bus_req_i,
   input wire logic [15:0]         rdata_o,
   input wire logic                ext_clock_a_pin_i,
   input wire logic                ext_clock_b_pin_i,
   input wire logic                ch2_overflow_i,
   input wire logic                ch1_io_a_pin_i,
   input wire logic                ch1_io_a_pin_o,
   input wire logic                ch1_io_a_pin_oe_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import timer_pkg::*;
   // ==========================================
   // decodes
   wire logic st_acc = bus_req_i.addr == `CH1_STATUS_ADDR;
   wire logic io_wr  = bus_req_i.wr && bus_req_i.addr == `CH1_IO_ADDR;
   wire logic gen_wr = bus_req_i.wr && bus_req_i.addr[15:3] == 13'h1ffb;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   // ==========================================
   // properties
   a_read_idle: assert property (!$past(bus_req_i.rd) |-> rdata_o == 16'h0000)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property (bus_req_i.rd && bus_req_i.addr == 16'h0000 |=> rdata_o == 16'h0000)
      else $error("unmapped read not zero");
   a_gen_readback: assert property (gen_wr ##1 (bus_req_i.rd && bus_req_i.addr == $past(bus_req_i.addr))
      |=> rdata_o == $past(bus_req_i.wdata, 2)) else $error("general register read back wrong");
   a_flag_one_kept: assert property ((bus_req_i.rd && st_acc) ##1 (rdata_o[4] && bus_req_i.wr && st_acc
      && bus_req_i.wdata[4]) ##1 (bus_req_i.rd && st_acc) |=> rdata_o[4]) else $error("flag lost on write of one");
   a_flag_clear: assert property ((bus_req_i.rd && st_acc) ##1 (rdata_o[4] && bus_req_i.wr && st_acc
      && !bus_req_i.wdata[4]) ##1 (bus_req_i.rd && st_acc) |=> !rdata_o[4]) else $error("flag not cleared");
   a_mode_ones: assert property (bus_req_i.rd && bus_req_i.addr == `CH1_MODE_ADDR |=> rdata_o[15:4] == 12'h00c)
      else $error("mode read upper bits wrong");
   a_init_high: assert property (io_wr && !bus_req_i.wdata[3] && bus_req_i.wdata[2] && bus_req_i.wdata[1:0] != 2'h0
      |=> !ch1_io_a_pin_oe_n_o && ch1_io_a_pin_o) else $error("initial high level missing");
   a_init_low: assert property (io_wr && !bus_req_i.wdata[3] && !bus_req_i.wdata[2] && bus_req_i.wdata[1:0] != 2'h0
      |=> !ch1_io_a_pin_oe_n_o && !ch1_io_a_pin_o) else $error("initial low level missing");
   a_out_off: assert property (io_wr && !bus_req_i.wdata[3] && bus_req_i.wdata[1:0] == 2'h0
      |=> ch1_io_a_pin_oe_n_o) else $error("pin driven while output disabled");
   a_capture_input: assert property (io_wr && bus_req_i.wdata[3] |=> ch1_io_a_pin_oe_n_o [*2])
      else $error("pin driven in capture use");
endmodule

/* timer_channel_control_test.sv */
// self-checking bench for timer_channel_control: register tasks and pin scenarios
// assumes timer_defs.svh, the pin model timer_pins_model and the port checker
`include "timer_defs.svh"
module timer_channel_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   import timer_pkg::*;
   logic        clk_sys_i      = 1'b0;
   logic        rst_n_i        = 1'b0;
   logic        ch2_overflow_i = 1'b0;
   reg_req_t    req            = '0;
   logic [15:0] rdata_o;
   logic        pin_a, pin_b, pin_io, io_wire, pin_o, oe_n;
   logic [15:0] v, g, a;
   int          n_mismatch     = 0;
   int          checked        = 0;
   int          sh [5]         = '{0, `DIV4_LOG2, `DIV16_LOG2, `DIV64_LOG2, `DIV256_LOG2};
   clk_sel_t    cs [5]         = '{CLK_DIV1, CLK_DIV4, CLK_DIV16, CLK_DIV64, CLK_DIV256};
   clk_sel_t    ps [4]         = '{CLK_EXT_A, CLK_EXT_B, CLK_EXT_A, CLK_EXT_B};
   logic [1:0]  pe [4]         = '{2'h0, 2'h0, 2'h1, 2'h2};
   logic [3:0]  ct [3]         = '{4'h2, 4'h5, 4'h0};
   logic        eb [3]         = '{1'b0, 1'b1, 1'b0};
   logic        ea [3]         = '{1'b1, 1'b0, 1'b0};
   always #4 clk_sys_i = ~clk_sys_i;
   assign io_wire = oe_n ? pin_io : pin_o;
   timer_pins_model part_u (.ext_a_o(pin_a), .ext_b_o(pin_b), .io_o(pin_io));
   timer_channel_control dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_req_i(req), .rdata_o(rdata_o),
      .ext_clock_a_pin_i(pin_a), .ext_clock_b_pin_i(pin_b), .ch2_overflow_i(ch2_overflow_i),
      .ch1_io_a_pin_i(io_wire), .ch1_io_a_pin_o(pin_o), .ch1_io_a_pin_oe_n_o(oe_n));
   // ==========================================
   // access and compare tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic inr(input logic [15:0] x, input logic [15:0] lo, input logic [15:0] hi);
      chk({15'h0, x >= lo && x <= hi}, 16'h0001);
   endtask
   task automatic op(input logic w, input logic r, input logic [15:0] ad, input logic [15:0] d);
      @(posedge clk_sys_i);
      req <= '{addr: ad, wdata: d, wr: w, rd: r};
   endtask
   task automatic idle();
      @(posedge clk_sys_i);
      req <= '0;
   endtask
   task automatic wr(input logic [15:0] ad, input logic [15:0] d);
      op(1'b1, 1'b0, ad, d);
      idle();
   endtask
   task automatic rd(input logic [15:0] ad, output logic [15:0] x);
      op(1'b0, 1'b1, ad, 16'h0000);
      idle();
      #1 x = rdata_o;
   endtask
   function automatic logic [15:0] ctl(input clr_sel_t c, input logic [1:0] e, input clk_sel_t s);
      return {9'h000, c, e, s};
   endfunction
   task automatic go(input logic [15:0] c);
      wr(`CH1_COUNTER_ADDR, 16'h0000);
      wr(`CH1_CONTROL_ADDR, c);
      wr(`START_ADDR, 16'h0002);
   endtask
   task automatic stop(output logic [15:0] x);
      wr(`START_ADDR, 16'h0000);
      rd(`CH1_COUNTER_ADDR, x);
   endtask
   task automatic results();
      $display("mismatches %0d, checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk_sys_i);
      n_mismatch++;
      results();
   end
   // ==========================================
   // scenarios
   initial begin
      repeat (6) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         a = `CH0_GENERAL_A_ADDR + 16'(2 * i);
         rd(a, v);
         chk(v, `GENERAL_RESET);
         op(1'b1, 1'b0, a, 16'ha5c0 + 16'(i));
         op(1'b0, 1'b1, a, 16'h0000);
         idle();
         #1 chk(rdata_o, 16'ha5c0 + 16'(i));
      end
      rd(16'h0000, v);
      chk(v, 16'h0000);
      for (int m = 0; m < 8; m++) begin
         wr(`CH1_MODE_ADDR, 16'(m));
         rd(`CH1_MODE_ADDR, v);
         chk(v, `MODE_READ_ONES | 16'(m));
      end
      wr(`CH1_MODE_ADDR, 16'h0000);
      for (int i = 0; i < 5; i++) begin
         go(ctl(CLR_NONE, 2'h0, cs[i]));
         repeat (512) @(posedge clk_sys_i);
         stop(v);
         inr(v, 16'(512 >> sh[i]) - 16'h1, 16'(512 >> sh[i]) + 16'h4);
      end
      for (int i = 0; i < 4; i++) begin
         go(ctl(CLR_NONE, pe[i], ps[i]));
         part_u.pulses(i % 2, 3);
         repeat (8) @(posedge clk_sys_i);
         stop(v);
         chk(v, pe[i][1] ? 16'h0006 : 16'h0003);
      end
      wr(`CH1_MODE_ADDR, 16'h0004);
      go(ctl(CLR_NONE, 2'h1, CLK_DIV1));
      part_u.quad(2);
      repeat (8) @(posedge clk_sys_i);
      stop(v);
      chk(v, 16'h0008);
      wr(`CH1_MODE_ADDR, 16'h0000);
      go(ctl(CLR_NONE, 2'h0, CLK_CH2));
      repeat (4) begin
         @(posedge clk_sys_i);
         ch2_overflow_i <= 1'b1;
         @(posedge clk_sys_i);
         ch2_overflow_i <= 1'b0;
      end
      stop(v);
      chk(v, 16'h0004);
      rd(`CH1_STATUS_ADDR, v);
      chk(v & 16'h0010, 16'h0000);
      go(ctl(CLR_NONE, 2'h0, CLK_DIV1));
      wr(`CH1_COUNTER_ADDR, 16'hfffd);
      repeat (4) @(posedge clk_sys_i);
      stop(v);
      rd(`CH1_STATUS_ADDR, v);
      chk(v & 16'h0010, 16'h0010);
      op(1'b0, 1'b1, `CH1_STATUS_ADDR, 16'h0000);
      op(1'b1, 1'b0, `CH1_STATUS_ADDR, 16'h0010);
      rd(`CH1_STATUS_ADDR, v);
      chk(v & 16'h0010, 16'h0010);
      wr(`CH1_STATUS_ADDR, 16'h0010);
      wr(`CH1_STATUS_ADDR, 16'h0000);
      rd(`CH1_STATUS_ADDR, v);
      chk(v & 16'h0010, 16'h0010);
      op(1'b0, 1'b1, `CH1_STATUS_ADDR, 16'h0000);
      op(1'b1, 1'b0, `CH1_STATUS_ADDR, 16'h0000);
      rd(`CH1_STATUS_ADDR, v);
      chk(v & 16'h0010, 16'h0000);
      for (int i = 0; i < 3; i++) begin
         wr(`CH1_COUNTER_ADDR, 16'h0000);
         wr(`CH1_GENERAL_A_ADDR, 16'h0005);
         wr(`CH1_IO_ADDR, {12'h000, ct[i]});
         #1 chk({14'h0, oe_n, oe_n ? 1'b0 : pin_o}, {14'h0, ct[i] == 4'h0, eb[i]});
         go(ctl(CLR_GEN_A, 2'h0, CLK_DIV1));
         repeat (40) @(posedge clk_sys_i);
         stop(v);
         inr(v, 16'h0000, 16'h0006);
         chk({14'h0, oe_n, oe_n ? 1'b0 : pin_o}, {14'h0, ct[i] == 4'h0, ea[i]});
      end
      wr(`CH1_GENERAL_B_ADDR, 16'h0003);
      go(ctl(CLR_GEN_B, 2'h0, CLK_DIV1));
      repeat (40) @(posedge clk_sys_i);
      stop(v);
      inr(v, 16'h0000, 16'h0003);
      wr(`CH1_IO_ADDR, 16'h0008);
      go(ctl(CLR_NONE, 2'h0, CLK_DIV1));
      repeat (20) @(posedge clk_sys_i);
      part_u.pulses(2, 1);
      repeat (8) @(posedge clk_sys_i);
      stop(v);
      rd(`CH1_GENERAL_A_ADDR, g);
      inr(g, 16'd20, v - 16'h1);
      wr(`CH1_IO_ADDR, 16'h000c);
      wr(`CH0_GENERAL_A_ADDR, 16'h000a);
      wr(`CH0_COUNTER_ADDR, 16'h0000);
      wr(`CH1_COUNTER_ADDR, 16'h0000);
      wr(`START_ADDR, 16'h0003);
      repeat (30) @(posedge clk_sys_i);
      wr(`START_ADDR, 16'h0000);
      rd(`CH1_GENERAL_A_ADDR, g);
      inr(g, 16'd9, 16'd12);
      wr(`SYNC_ADDR, 16'h0003);
      wr(`CH0_CONTROL_ADDR, 16'h0001);
      wr(`CH0_GENERAL_A_ADDR, 16'h0014);
      wr(`CH0_COUNTER_ADDR, 16'h0000);
      go(ctl(CLR_SYNC, 2'h0, CLK_DIV1));
      wr(`START_ADDR, 16'h0003);
      repeat (100) @(posedge clk_sys_i);
      stop(v);
      inr(v, 16'h0000, 16'd22);
      results();
   end
endmodule
bind timer_channel_control timer_channel_control_sva chk_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
   .bus_req_i(bus_req_i), .rdata_o(rdata_o), .ext_clock_a_pin_i(ext_clock_a_pin_i),
   .ext_clock_b_pin_i(ext_clock_b_pin_i), .ch2_overflow_i(ch2_overflow_i), .ch1_io_a_pin_i(ch1_io_a_pin_i),
   .ch1_io_a_pin_o(ch1_io_a_pin_o), .ch1_io_a_pin_oe_n_o(ch1_io_a_pin_oe_n_o));

/* timer_defs.svh */
// offsets, field positions, reset values and timing counts of the timer channels
// assumes a 16-bit register port with byte addresses and even-aligned registers
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// ==========================================
// register offsets
`define CH0_GENERAL_A_ADDR 16'hffd8
`define CH0_GENERAL_B_ADDR 16'hffda
`define CH0_GENERAL_C_ADDR 16'hffdc
`define CH0_GENERAL_D_ADDR 16'hffde
`define CH1_CONTROL_ADDR   16'hff80
`define CH1_MODE_ADDR      16'hff82
`define CH1_IO_ADDR        16'hff84
`define CH1_STATUS_ADDR    16'hff86
`define CH1_COUNTER_ADDR   16'hff88
`define CH1_GENERAL_A_ADDR 16'hff8a
`define CH1_GENERAL_B_ADDR 16'hff8c
`define START_ADDR         16'hff8e
`define SYNC_ADDR          16'hff90
`define CH0_COUNTER_ADDR   16'hff92
`define CH0_CONTROL_ADDR   16'hff94

// ==========================================
// field positions
`define OVF_BIT            4
`define IO_INIT_BIT        2

// ==========================================
// reset values
`define GENERAL_RESET      16'hffff
`define COUNTER_RESET      16'h0000
`define COUNTER_MAX        16'hffff
`define CONTROL_RESET      7'h00
`define MODE_RESET         4'h0
`define IO_RESET           4'h0
`define MODE_READ_ONES     16'h00c0

// ==========================================
// prescaler divide ratios as powers of two
`define DIV4_LOG2          2
`define DIV16_LOG2         4
`define DIV64_LOG2         6
`define DIV256_LOG2        8

`endif

/* timer_pins_model.sv */
// model of the pins facing the timer: external clocks A and B and the io pin input side
// assumes the bench calls pulses and resolves the io pin level itself
module timer_pins_model (
   output logic ext_a_o,
   output logic ext_b_o,
   output logic io_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {ext_a_o, ext_b_o, io_o} = 3'h0;
   // ==========================================
   // pulse trains, slow against the system clock
   task automatic pulses(input int sel, input int n);
      repeat (n) begin
         #37;
         if (sel == 0) ext_a_o = 1'b1;
         else if (sel == 1) ext_b_o = 1'b1;
         else io_o = 1'b1;
         #41;
         if (sel == 0) ext_a_o = 1'b0;
         else if (sel == 1) ext_b_o = 1'b0;
         else io_o = 1'b0;
      end
   endtask
   // quadrature cycles, a leading b: four counting edges each
   task automatic quad(input int n);
      repeat (n) begin
         #37 ext_a_o = 1'b1;
         #37 ext_b_o = 1'b1;
         #37 ext_a_o = 1'b0;
         #37 ext_b_o = 1'b0;
      end
   endtask
endmodule

/* timer_pkg.sv */
// types shared by the timer channel files
// assumes the constants of timer_defs.svh for offsets and reset values
package timer_pkg;

   // ==========================================
   // count source, clear source and mode codes
   typedef enum logic [2:0] {
      CLK_DIV1   = 3'h0,
      CLK_DIV4   = 3'h1,
      CLK_DIV16  = 3'h2,
      CLK_DIV64  = 3'h3,
      CLK_EXT_A  = 3'h4,
      CLK_EXT_B  = 3'h5,
      CLK_DIV256 = 3'h6,
      CLK_CH2    = 3'h7
   } clk_sel_t;

   typedef enum logic [1:0] {
      CLR_NONE  = 2'h0,
      CLR_GEN_A = 2'h1,
      CLR_GEN_B = 2'h2,
      CLR_SYNC  = 2'h3
   } clr_sel_t;

   typedef enum logic [3:0] {
      MODE_NORMAL = 4'h0,
      MODE_RSVD   = 4'h1,
      MODE_PWM1   = 4'h2,
      MODE_PWM2   = 4'h3,
      MODE_PHASE1 = 4'h4,
      MODE_PHASE2 = 4'h5,
      MODE_PHASE3 = 4'h6,
      MODE_PHASE4 = 4'h7
   } mode_t;

   // ==========================================
   // register layouts and bus request
   typedef struct packed {
      clr_sel_t   clear;
      logic [1:0] edge_sel;
      clk_sel_t   clk_sel;
   } ch1_control_t;

   typedef struct packed {
      logic       capture;
      logic       init_or_ch0;
      logic [1:0] action;
   } io_ctrl_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

endpackage
